// [common/sei_pkg.sv]
// Purpose: Shared constants for the identification-page link, both ends.
// Assumes: 25 MHz system clock; mode-0 serial link.
// Notes:   Byte ECC helpers live here so the page store stays compact.
package sei_pkg;
  localparam int CLK_NS            = 40;
  // Opcodes; A7 of the address byte picks lock status/lock over page access
  localparam logic [7:0] OP_UNLOCK = 8'h06;
  localparam logic [7:0] OP_RD     = 8'h83;
  localparam logic [7:0] OP_WR     = 8'h82;
  localparam logic [7:0] OP_NONE   = 8'h00;
  localparam logic [7:0] LOCK_ADDR = 8'h80;
  localparam int A7_BIT            = 7;
  localparam int LOCK_DATA_BIT     = 1;
  localparam int PAGE_BYTES        = 16;
  // Arbitrary identification value, three leading bytes
  localparam logic [23:0] ID_CODE  = 24'hA5C31E;
  localparam logic [7:0] ERASED    = 8'hFF;
  // Self-timed write cycle
  localparam int WRITE_CYCLE_NS    = 5000000;
  localparam int WRITE_CYCLE_CLKS  = WRITE_CYCLE_NS / CLK_NS;
  localparam int SCLK_HALF_CLKS    = 4;
  // Host register map and fields
  localparam logic [7:0] REG_CMD   = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_TX    = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0C;
  localparam logic [7:0] REG_RX    = 8'h10;
  localparam int CMD_KIND_LSB      = 0;
  localparam int CMD_LEN_LSB       = 4;
  localparam logic [2:0] K_UNLOCK  = 3'h0;
  localparam logic [2:0] K_IDRD    = 3'h1;
  localparam logic [2:0] K_IDWR    = 3'h2;
  localparam logic [2:0] K_LSRD    = 3'h3;
  localparam logic [2:0] K_LOCK    = 3'h4;
  // Syndrome codes of data bits 7..0 (no power of two, all distinct)
  localparam logic [31:0] ECC_CODE = 32'hCBA97653;

  function automatic logic [3:0] ecc_gen(input logic [7:0] d);
    logic [3:0] c;
    c = 4'h0;
    for (int k = 0; k < 8; k++) begin
      if (d[k]) c = c ^ ECC_CODE[k*4 +: 4];
    end
    return c;
  endfunction

  // Codeword is {check[3:0], data[7:0]}; one flipped data bit is repaired
  function automatic logic [7:0] ecc_fix(input logic [11:0] cw);
    logic [3:0] syn;
    logic [7:0] d;
    d   = cw[7:0];
    syn = cw[11:8] ^ ecc_gen(cw[7:0]);
    for (int k = 0; k < 8; k++) begin
      if (syn == ECC_CODE[k*4 +: 4]) d[k] = ~d[k];
    end
    return d;
  endfunction
endpackage

// [common/sei_link_if.sv]
// Purpose: Serial link between the page controller end and the device end.
// Assumes: One device on the wire; output enables are active low.
// Notes:   An undriven data-out line reads high, as with a pull-up.
`timescale 1ns/1ns
interface sei_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  wire  miso_line;

  // Resolve the shared data-out wire from its enable
  assign miso_line = miso_oe_n ? 1'b1 : miso;

  modport dev (
    input  cs_n,
    input  sclk,
    input  mosi,
    output miso,
    output miso_oe_n
  );
  modport host (
    output cs_n,
    output sclk,
    output mosi,
    input  miso_line
  );
endinterface

// [rtl/sei_id_dev.sv]
// Purpose: Device end: identification page read, write, lock status, lock.
// Assumes: Mode-0 link sampled by clk; link clock far slower than clk.
// Notes:   rst_n is power-on reset; factory_rst_n loads the delivery state.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ns
// Functional notes
// - Page read shifts byte MSB first.
// - Master sends A8 zero, upper bits ignored.
// - Any page byte may start reads.
// - Sequential read advances address per byte.
// - Master never reads past page end.
// - Chip select rise ends read anytime.
// - Page read ignored during write cycle.
// - Leading bytes hold writable identification code.
// - Write needs opcode, address, data byte.
// - Write cycle starts at select rise.
// - Writes dropped when busy or fully protected.
// - Lock status read uses A7 one.
// - Lock flag sits in status LSB.
// - Status byte repeats while still selected.
// - Lock status read refused while busy.
// - Lock data byte carries bit one set.
// - Lock runs only on byte boundary.
// - Reset ignores orders, then idles deselected.
// - Reset clears permit latch and busy.
// - Single bit errors corrected per byte.
// - Delivery: identification code, protection off.
// - Data out driven only while selected.
// - Writes need prior write unlock order.
module sei_id_dev
  import sei_pkg::*;
#(
  parameter int WCYC = WRITE_CYCLE_CLKS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic factory_rst_n,
  sei_link_if.dev   link,
  input  wire logic protect_hi_bit,
  input  wire logic protect_lo_bit,
  output logic      write_busy_flag,
  output logic      write_permit_latch,
  output logic      id_locked
);
  typedef enum logic [4:0] {
    D_CMD  = 5'b00001,
    D_ADDR = 5'b00010,
    D_WIN  = 5'b00100,
    D_OUT  = 5'b01000,
    D_SKIP = 5'b10000
  } sei_dst_t;

  sei_dst_t    state;
  logic        cs_m, cs_s, cs_d, sck_m, sck_s, sck_d, mo_m, mo_s;
  logic [2:0]  bit_cnt;
  logic [2:0]  out_cnt;
  logic [7:0]  in_sh;
  logic [7:0]  out_sh;
  logic [7:0]  opc;
  logic        a7;
  logic [4:0]  ptr;
  logic        got_data;
  logic        lock_arm;
  logic [7:0]  stage [PAGE_BYTES];
  logic [15:0] stage_v;
  logic [11:0] mem [PAGE_BYTES];
  logic [23:0] busy_cnt;

  // Edge detection reads only the second synchroniser stage
  wire       sel       = ~cs_s;
  wire       sck_rise  = sel & sck_s & ~sck_d;
  wire       sck_fall  = sel & ~sck_s & sck_d;
  wire       cs_rise   = cs_s & ~cs_d;
  wire       byte_done = sck_rise & (bit_cnt == 3'h7);
  wire [7:0] in_byte   = {in_sh[6:0], mo_s};
  wire       busy      = (busy_cnt != 24'h0);
  wire       prot_all  = protect_hi_bit & protect_lo_bit;
  wire [7:0] rd_byte   = ecc_fix(mem[ptr[3:0]]);
  wire [7:0] status    = {7'h00, id_locked};
  wire [7:0] cur_byte  = a7 ? status : rd_byte;
  wire       boundary  = (bit_cnt == 3'h0);
  // Write or lock is honoured only when every guard passes
  wire       wr_ok     = cs_rise & (opc == OP_WR) & got_data & boundary
                         & write_permit_latch & ~busy & ~prot_all
                         & ~id_locked;
  wire       do_lock   = wr_ok & a7 & lock_arm;
  wire       do_write  = wr_ok & ~a7;
  wire       do_unlock = cs_rise & (opc == OP_UNLOCK) & boundary & (state == D_SKIP);

  assign write_busy_flag = busy;

  // Two-stage synchronisers for the link pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_m  <= 1'b1;
      cs_s  <= 1'b1;
      cs_d  <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      mo_m  <= 1'b0;
      mo_s  <= 1'b0;
    end else begin
      cs_m  <= link.cs_n;
      cs_s  <= cs_m;
      cs_d  <= cs_s;
      sck_m <= link.sclk;
      sck_s <= sck_m;
      sck_d <= sck_s;
      mo_m  <= link.mosi;
      mo_s  <= mo_m;
    end
  end

  // Input shifter and frame decoder; state is lost on every select rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= D_CMD;
      bit_cnt  <= 3'h0;
      in_sh    <= 8'h00;
      opc      <= OP_NONE;
      a7       <= 1'b0;
      got_data <= 1'b0;
      lock_arm <= 1'b0;
      stage_v  <= 16'h0000;
    end else if (cs_rise) begin
      state    <= D_CMD;
      bit_cnt  <= 3'h0;
      opc      <= OP_NONE;
      got_data <= 1'b0;
      stage_v  <= 16'h0000;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      in_sh   <= in_byte;
      if (byte_done) begin
        unique case (state)
          D_CMD: begin
            opc   <= in_byte;
            state <= (in_byte == OP_RD || in_byte == OP_WR) ? D_ADDR : D_SKIP;
          end
          D_ADDR: begin
            a7 <= in_byte[A7_BIT];
            if (opc == OP_WR) begin
              state <= D_WIN;
            end else begin
              state <= busy ? D_SKIP : D_OUT;
            end
          end
          D_WIN: begin
            got_data <= 1'b1;
            lock_arm <= in_byte[LOCK_DATA_BIT];
            if (!a7) begin
              stage[ptr[3:0]]   <= in_byte;
              stage_v[ptr[3:0]] <= 1'b1;
            end
          end
          D_OUT, D_SKIP: begin
          end
        endcase
      end
    end
  end

  // Page pointer and output shifter; data changes on falling link edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr     <= 5'h00;
      out_cnt <= 3'h0;
      out_sh  <= 8'h00;
      link.miso <= 1'b0;
    end else if (cs_rise) begin
      // Park the data bit low so a refused read shows zeros, not a stale bit
      link.miso <= 1'b0;
    end else if (byte_done && state == D_ADDR) begin
      ptr     <= in_byte[4:0];
      out_cnt <= 3'h0;
    end else if (byte_done && state == D_WIN) begin
      ptr <= ptr + 5'h01;
    end else if (sck_fall && state == D_OUT) begin
      out_cnt   <= out_cnt + 3'h1;
      link.miso <= (out_cnt == 3'h0) ? cur_byte[7] : out_sh[7];
      out_sh    <= (out_cnt == 3'h0) ? {cur_byte[6:0], 1'b0} : {out_sh[6:0], 1'b0};
      // Status mode holds the pointer so the same byte repeats
      if (out_cnt == 3'h7 && !a7) begin
        ptr <= ptr + 5'h01;
      end
    end
  end

  // Output enable follows select so a shared bus stays free otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.miso_oe_n <= 1'b1;
    end else begin
      link.miso_oe_n <= cs_s;
    end
  end

  // Write permit latch and self-timed write cycle timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_permit_latch <= 1'b0;
      busy_cnt           <= 24'h0;
    end else if (do_lock || do_write) begin
      write_permit_latch <= 1'b0;
      busy_cnt           <= 24'(WCYC);
    end else begin
      if (do_unlock) write_permit_latch <= 1'b1;
      if (busy) busy_cnt <= busy_cnt - 24'h1;
    end
  end

  // Nonvolatile page and lock flag; kept across power-on reset
  always_ff @(posedge clk or negedge factory_rst_n) begin
    if (!factory_rst_n) begin
      id_locked <= 1'b0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        mem[i] <= {ecc_gen(ERASED), ERASED};
      end
      mem[0] <= {ecc_gen(ID_CODE[23:16]), ID_CODE[23:16]};
      mem[1] <= {ecc_gen(ID_CODE[15:8]), ID_CODE[15:8]};
      mem[2] <= {ecc_gen(ID_CODE[7:0]), ID_CODE[7:0]};
    end else begin
      if (do_lock) id_locked <= 1'b1;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (do_write && stage_v[i]) begin
          mem[i] <= {ecc_gen(stage[i]), stage[i]};
        end
      end
    end
  end
endmodule

// [rtl/sei_id_host.sv]
// Purpose: Controller end: runs one page order per command register write.
// Assumes: Software waits for the busy bit to clear between orders.
// Notes:   Up to four data bytes per frame; no queueing.
`timescale 1ns/1ns
module sei_id_host
  import sei_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  sei_link_if.host         link,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_LOW  = 5'b00010,
    H_HIGH = 5'b00100,
    H_TAIL = 5'b01000,
    H_GAP  = 5'b10000
  } sei_hst_t;

  sei_hst_t    fsm;
  logic [2:0]  kind;
  logic [1:0]  len_m1;
  logic [4:0]  page_addr;
  logic [31:0] tx_data;
  logic [31:0] rx_data;
  logic [47:0] sh;
  logic [5:0]  bitn;
  logic [1:0]  ph;
  logic        mi_m, mi_s;

  // Frame from the command word being written plus latched address and data; bit count from the latched order
  wire [2:0]  new_kind = reg_wdata[CMD_KIND_LSB +: 3];
  wire [1:0]  new_len  = reg_wdata[CMD_LEN_LSB +: 2];
  wire        start    = reg_wr & (reg_addr == REG_CMD) & (fsm == H_IDLE);
  // A8 stays zero in the opcode; A7 selects the lock flavour
  wire        is_rd    = (new_kind == K_IDRD) | (new_kind == K_LSRD);
  wire        is_lk    = (new_kind == K_LSRD) | (new_kind == K_LOCK);
  wire [7:0]  opcode   = (new_kind == K_UNLOCK) ? OP_UNLOCK : (is_rd ? OP_RD : OP_WR);
  wire [7:0]  abyte    = is_lk ? LOCK_ADDR : {3'h0, page_addr};
  wire [47:0] frame    = {opcode, abyte, tx_data[7:0], tx_data[15:8],
                          tx_data[23:16], tx_data[31:24]};
  wire [5:0]  nbits    = (kind == K_UNLOCK) ? 6'd8 : 6'(6'd16 + {len_m1, 3'h0} + 6'd8);
  wire        ph_end   = (ph == 2'(SCLK_HALF_CLKS - 1));
  wire        busy     = (fsm != H_IDLE);
  wire [31:0] rd_mux   = (reg_addr == REG_CMD)  ? {26'h0, len_m1, 1'b0, kind} :
                         (reg_addr == REG_ADDR) ? {27'h0, page_addr} :
                         (reg_addr == REG_TX)   ? tx_data :
                         (reg_addr == REG_STAT) ? {31'h0, busy} :
                         (reg_addr == REG_RX)   ? rx_data : 32'h0;

  // Register writes and read data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kind      <= K_UNLOCK;
      len_m1    <= 2'h0;
      page_addr <= 5'h00;
      tx_data   <= 32'h0;
      reg_rdata <= 32'h0;
    end else begin
      if (start) begin
        kind   <= new_kind;
        len_m1 <= new_len;
      end
      if (reg_wr && reg_addr == REG_ADDR) page_addr <= reg_wdata[4:0];
      if (reg_wr && reg_addr == REG_TX) tx_data <= reg_wdata;
      if (reg_rd) reg_rdata <= rd_mux;
    end
  end

  // Returned data line through two flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mi_m <= 1'b1;
      mi_s <= 1'b1;
    end else begin
      mi_m <= link.miso_line;
      mi_s <= mi_m;
    end
  end

  // Link sequencer: clock divided from clk, mode 0, data set while low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fsm       <= H_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
      sh        <= 48'h0;
      bitn      <= 6'h00;
      ph        <= 2'h0;
      rx_data   <= 32'h0;
    end else begin
      ph <= ph_end ? 2'h0 : ph + 2'h1;
      unique case (fsm)
        H_IDLE: begin
          ph <= 2'h0;
          if (start) begin
            fsm       <= H_LOW;
            link.cs_n <= 1'b0;
            link.mosi <= frame[47];
            sh        <= {frame[46:0], 1'b0};
            bitn      <= 6'h00;
          end
        end
        H_LOW: begin
          if (ph_end) begin
            fsm       <= H_HIGH;
            link.sclk <= 1'b1;
          end
        end
        H_HIGH: begin
          if (ph_end) begin
            link.sclk <= 1'b0;
            bitn      <= bitn + 6'h01;
            // Sampling late in the high phase absorbs both synchroniser delays
            if (bitn >= 6'd16) rx_data <= {rx_data[30:0], mi_s};
            if (bitn == nbits - 6'h01) begin
              fsm <= H_TAIL;
            end else begin
              fsm       <= H_LOW;
              link.mosi <= sh[47];
              sh        <= {sh[46:0], 1'b0};
            end
          end
        end
        H_TAIL: begin
          if (ph_end) begin
            fsm       <= H_GAP;
            link.cs_n <= 1'b1;
          end
        end
        H_GAP: begin
          if (ph_end) fsm <= H_IDLE;
        end
      endcase
    end
  end
endmodule

// [tb/sei_link_assertions.sv]
// Purpose: Wire-level checks on the identification-page serial link.
// Assumes: Sees only link signals plus clk and rst_n; one clock domain.
// Notes:   Sync lag of the device end is allowed for in the select windows.
`timescale 1ns/1ns
module sei_link_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic miso,
  input wire logic miso_oe_n
);
  logic [7:0] nbits;
  logic       sclk_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Link clock rises per frame; cleared while deselected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nbits  <= 8'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) nbits <= 8'h00;
      else if (sclk && !sclk_q) nbits <= nbits + 8'h01;
    end
  end

  // High phase of the link clock lasts four system clocks
  sequence s_high_phase;
    sclk [*4] ##1 !sclk;
  endsequence

  a_desel_quiet: assert property (cs_n [*5] |-> miso_oe_n)
    else $error("data out driven while deselected");
  a_sel_drive: assert property (!cs_n [*5] |-> !miso_oe_n)
    else $error("data out not driven while selected");
  a_release_idle: assert property ($rose(rst_n) |-> cs_n && !sclk && miso_oe_n)
    else $error("link not idle after reset");
  a_sclk_half: assert property ($rose(sclk) |-> s_high_phase)
    else $error("link clock high phase wrong");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("link clock moves while deselected");
  a_miso_steady: assert property ($rose(sclk) |=> $stable(miso) [*3])
    else $error("data out changes in clock high phase");
  a_byte_end: assert property ($rose(cs_n) |-> nbits[2:0] == 3'h0 && nbits != 8'h00)
    else $error("select rose off a byte boundary");
  a_read_stop: assert property ($rose(cs_n) |-> ##[1:5] miso_oe_n)
    else $error("data out still driven after select rise");
endmodule

// [tb/spi_eeprom_id_page_lock_tb_top.sv]
// Purpose: Self-checking bench joining controller end and device end.
// Assumes: Write cycle shortened to WC clocks so reads can overlap it.
// Notes:   Error-correction repair cannot be provoked from the ports.
`timescale 1ns/1ns
module spi_eeprom_id_page_lock_tb_top;
  import sei_pkg::*;
  localparam int WC = 800;
  logic        clk;
  logic        rst_n;
  logic        factory_rst_n;
  logic        protect_hi_bit;
  logic        protect_lo_bit;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        busy;
  logic        permit;
  logic        locked;
  logic [31:0] rx;
  int          failures;
  int          checks;
  int          cyc;
  int          bcnt;
  int          blen;

  sei_link_if sei_link_if_i ();
  sei_id_host sei_id_host_i (.clk(clk), .rst_n(rst_n), .link(sei_link_if_i.host),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  sei_id_dev #(.WCYC(WC)) sei_id_dev_i (.clk(clk), .rst_n(rst_n),
    .factory_rst_n(factory_rst_n), .link(sei_link_if_i.dev),
    .protect_hi_bit(protect_hi_bit), .protect_lo_bit(protect_lo_bit),
    .write_busy_flag(busy), .write_permit_latch(permit), .id_locked(locked));
  sei_link_assertions sei_link_assertions_i (.clk(clk), .rst_n(rst_n),
    .cs_n(sei_link_if_i.cs_n), .sclk(sei_link_if_i.sclk), .miso(sei_link_if_i.miso),
    .miso_oe_n(sei_link_if_i.miso_oe_n));

  always #20 clk = ~clk;

  // Hang guard and write-cycle length monitor
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 60000) begin
      failures = failures + 1;
      end_of_test();
    end else if (busy === 1'b1) begin
      bcnt = bcnt + 1;
    end else if (bcnt != 0) begin
      blen = bcnt;
      bcnt = 0;
    end
  end

  task automatic end_of_test();
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // One frame: load address and data, start, wait for the controller to settle
  task automatic run(input logic [2:0] k, input logic [1:0] nm1, input logic [7:0] a,
                     input logic [31:0] tx);
    logic [31:0] stat;
    int          n;
    reg_write(REG_ADDR, {24'h000000, a});
    reg_write(REG_TX, tx);
    reg_write(REG_CMD, {26'h0000000, nm1, 1'b0, k});
    stat = 32'h00000001;
    n    = 0;
    while (stat[0] !== 1'b0 && n < 400) begin
      reg_read(REG_STAT, stat);
      n = n + 1;
    end
    // A frame that never finishes must not slip through as a pass
    check("frame_end", stat, 32'h0);
    repeat (8) @(posedge clk);
    reg_read(REG_RX, rx);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n = n + 1;
    end
    check("busy_end", {31'h0, busy}, 32'h0);
  endtask

  task automatic t_reset();
    check("busy", {31'h0, busy}, 32'h0);
    check("permit", {31'h0, permit}, 32'h0);
    check("locked", {31'h0, locked}, 32'h0);
    check("idle_line", {31'h0, sei_link_if_i.miso_line}, 32'h1);
    reg_read(REG_STAT, rx);
    check("stat", rx, 32'h0);
    reg_read(8'h40, rx);
    check("unmapped", rx, 32'h0);
    run(K_IDRD, 2'h3, 8'h00, 32'h0);
    check("delivery", rx, {ID_CODE, ERASED});
    reg_read(REG_CMD, rx);
    check("cmd_back", rx, {26'h0, 2'h3, 1'b0, K_IDRD});
  endtask

  task automatic t_no_unlock();
    run(K_IDWR, 2'h0, 8'h05, 32'h5A);
    repeat (4) @(posedge clk);
    check("nounlock_busy", {31'h0, busy}, 32'h0);
    run(K_IDRD, 2'h0, 8'h05, 32'h0);
    check("nounlock_data", {24'h0, rx[7:0]}, {24'h0, ERASED});
  endtask

  task automatic t_write_busy();
    run(K_UNLOCK, 2'h0, 8'h00, 32'h0);
    check("permit_set", {31'h0, permit}, 32'h1);
    run(K_IDWR, 2'h1, 8'h0E, 32'h2211);
    check("wr_busy", {31'h0, busy}, 32'h1);
    check("permit_clr", {31'h0, permit}, 32'h0);
    run(K_IDRD, 2'h0, 8'h0E, 32'h0);
    check("rd_refused", {24'h0, rx[7:0]}, 32'h0);
    run(K_LSRD, 2'h0, 8'h00, 32'h0);
    check("ls_refused", {24'h0, rx[7:0]}, 32'h0);
    wait_idle();
    // Let the busy monitor close its count before it is read
    @(posedge clk);
    check("cycle_len", {31'h0, (blen >= WC - 2) && (blen <= WC + 2)}, 32'h1);
    run(K_IDRD, 2'h1, 8'h0E, 32'h0);
    check("wr_data", {16'h0, rx[15:0]}, 32'h1122);
  endtask

  task automatic t_id_overwrite();
    run(K_UNLOCK, 2'h0, 8'h00, 32'h0);
    run(K_IDWR, 2'h0, 8'h00, 32'h3C);
    wait_idle();
    run(K_IDRD, 2'h2, 8'h00, 32'h0);
    check("id_over", {8'h0, rx[23:0]}, {8'h0, 8'h3C, ID_CODE[15:0]});
  endtask

  // Both protect bits set: page write and lock are dropped
  task automatic t_protect();
    @(posedge clk);
    protect_hi_bit <= 1'b1;
    protect_lo_bit <= 1'b1;
    run(K_UNLOCK, 2'h0, 8'h00, 32'h0);
    run(K_IDWR, 2'h0, 8'h03, 32'hAA);
    check("bp_wr", {31'h0, busy}, 32'h0);
    run(K_UNLOCK, 2'h0, 8'h00, 32'h0);
    run(K_LOCK, 2'h0, 8'h00, 32'h02);
    check("bp_lock", {30'h0, busy, locked}, 32'h0);
    @(posedge clk);
    protect_hi_bit <= 1'b0;
    protect_lo_bit <= 1'b0;
    run(K_IDRD, 2'h0, 8'h03, 32'h0);
    check("bp_data", {24'h0, rx[7:0]}, {24'h0, ERASED});
  endtask

  task automatic t_lock();
    run(K_UNLOCK, 2'h0, 8'h00, 32'h0);
    run(K_LOCK, 2'h0, 8'h00, 32'hFD);
    check("lock_bad", {30'h0, busy, locked}, 32'h0);
    run(K_LSRD, 2'h0, 8'h00, 32'h0);
    check("ls_open", {24'h0, rx[7:0]}, 32'h0);
    run(K_UNLOCK, 2'h0, 8'h00, 32'h0);
    run(K_LOCK, 2'h0, 8'h00, 32'h02);
    check("lock_busy", {31'h0, busy}, 32'h1);
    // Flag is already set here, so a served status read would show one
    run(K_LSRD, 2'h0, 8'h00, 32'h0);
    check("ls_busy", {24'h0, rx[7:0]}, 32'h0);
    wait_idle();
    check("locked", {31'h0, locked}, 32'h1);
    run(K_LSRD, 2'h2, 8'h00, 32'h0);
    check("ls_locked", {8'h0, rx[23:0]}, 32'h010101);
    run(K_UNLOCK, 2'h0, 8'h00, 32'h0);
    run(K_IDWR, 2'h0, 8'h06, 32'h66);
    check("lk_wr", {31'h0, busy}, 32'h0);
    run(K_IDRD, 2'h0, 8'h06, 32'h0);
    check("lk_data", {24'h0, rx[7:0]}, {24'h0, ERASED});
  endtask

  // Power-on reset alone keeps page and lock, clears latch and busy
  task automatic t_reinit();
    run(K_UNLOCK, 2'h0, 8'h00, 32'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("por_latch", {30'h0, busy, permit}, 32'h0);
    check("por_lock", {31'h0, locked}, 32'h1);
    run(K_IDRD, 2'h0, 8'h00, 32'h0);
    check("por_page", {24'h0, rx[7:0]}, 32'h3C);
  endtask

  initial begin
    clk            = 1'b0;
    rst_n          = 1'b0;
    factory_rst_n  = 1'b0;
    protect_hi_bit = 1'b0;
    protect_lo_bit = 1'b0;
    reg_addr       = 8'h00;
    reg_wdata      = 32'h0;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    failures       = 0;
    checks         = 0;
    cyc            = 0;
    bcnt           = 0;
    blen           = 0;
    repeat (6) @(posedge clk);
    rst_n         <= 1'b1;
    factory_rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_no_unlock();
    t_write_busy();
    t_id_overwrite();
    t_protect();
    t_lock();
    t_reinit();
    end_of_test();
  end
endmodule
